// File: icpc_control_port.sv
// Two-wire target control port with book/page paging and running checksums
`include "icpc_map.svh"
`timescale 1ns/100ps
`default_nettype none

module icpc_control_port
  import icpc_pkg::*;
(
  input wire logic clk_sys_i,       // Register clock, 100 MHz
  input wire logic rst_n_i,         // Synchronous reset, active low
  input wire logic clk_link_i,      // Bus sampling clock
  input wire logic power_down_n_i,  // Power-down pin, active low
  input wire logic [1:0] strap_i,   // Decoded address strap level
  input wire logic scl_i,           // Bus clock pin level
  output logic scl_o,               // Bus clock drive value
  output logic scl_oe_n_o,          // Bus clock drive enable, low drives
  input wire logic sda_i,           // Bus data pin level
  output logic sda_o,               // Bus data drive value
  output logic sda_oe_n_o,          // Bus data drive enable, low drives
  output logic [7:0] page_o,        // Current page
  output logic [7:0] book_o         // Current book
);

  // ---------------- Link domain ----------------
  logic link_rst_n;
  logic scl_s;
  logic sda_s;
  logic pdn_s;
  logic [1:0] strap_s;
  logic ack_s;
  logic scl_d;
  logic sda_d;
  logic [1:0] strap;
  logic strap_done;
  icpc_state_t state;
  icpc_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] txsh;
  logic [7:0] next_txsh;
  logic loaded;
  logic next_loaded;
  logic rw;
  logic next_rw;
  logic mack;
  logic next_mack;
  logic issue;
  icpc_event_t issue_kind;
  logic [7:0] issue_byte;
  logic req_tog;
  icpc_event_t req_kind;
  logic [7:0] req_byte;
  logic sda_low;
  logic scl_hold;

  // ---------------- System domain ----------------
  logic req_s;
  logic req_d;
  logic ack_tog;
  logic [7:0] rd_data;
  logic [7:0] ptr;
  logic [7:0] page;
  logic [7:0] book;
  logic [7:0] crc;
  logic [7:0] xsum;
  logic [7:0] mem [0:255];

  // Reset and pins enter the link domain through two flops each
  icpc_sync2 #(.W(6)) u_link_sync (
    .clk_i(clk_link_i),
    .d_i({rst_n_i, scl_i, sda_i, power_down_n_i, strap_i}),
    .q_o({link_rst_n, scl_s, sda_s, pdn_s, strap_s})
  );

  // Acknowledge toggle back from the register domain
  icpc_sync2 #(.W(1)) u_ack_sync (
    .clk_i(clk_link_i),
    .d_i(ack_tog),
    .q_o(ack_s)
  );

  // Request toggle into the register domain
  icpc_sync2 #(.W(1)) u_req_sync (
    .clk_i(clk_sys_i),
    .d_i(req_tog),
    .q_o(req_s)
  );

  // Bus condition decode on synchronised levels
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;
  wire rx_full = scl_fall & (cnt == `ICPC_RX_LAST);
  wire addr_hit = shreg[7:1] == {`ICPC_ADDR_HI, strap};
  wire busy = req_tog ^ ack_s;
  wire wait_data = busy | ((state == ST_RDATA) & ~loaded);
  wire ack_state = (state == ST_ADDR_ACK) | (state == ST_SUB_ACK) | (state == ST_WDATA_ACK);

  // Edge history, taken from second sync stage only
  always_ff @(posedge clk_link_i) begin
    scl_d <= scl_s;
    sda_d <= sda_s;
  end

  // Strap caught once after reset release; later pin changes ignored
  always_ff @(posedge clk_link_i) begin
    if (!link_rst_n) begin
      strap <= `ICPC_STRAP_RST;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      strap <= strap_s;
      strap_done <= 1'b1;
    end
  end

  // Bit engine next state; oversampling covers 100 and 400 kHz alike
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_txsh = txsh;
    next_loaded = loaded;
    next_rw = rw;
    next_mack = mack;
    issue = 1'b0;
    issue_kind = EV_WR;
    issue_byte = shreg;
    if (!pdn_s || !strap_done) begin
      next_state = ST_IDLE;
    end else if (bus_start) begin
      next_state = ST_ADDR;
      next_cnt = `ICPC_CNT_RST;
    end else if (bus_stop) begin
      next_state = ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          next_cnt = `ICPC_CNT_RST;
        end
        ST_ADDR, ST_SUB, ST_WDATA: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_s};
            next_cnt = 4'(cnt + `ICPC_CNT_ONE);
          end else if (rx_full) begin
            next_cnt = `ICPC_CNT_RST;
            if (state == ST_ADDR) begin
              if (addr_hit) begin
                next_state = ST_ADDR_ACK;
                next_rw = shreg[0];
                if (shreg[0] == `ICPC_DIR_READ) begin
                  issue = 1'b1;
                  issue_kind = EV_RD;
                end
              end else begin
                next_state = ST_IDLE;
              end
            end else if (state == ST_SUB) begin
              next_state = ST_SUB_ACK;
              issue = 1'b1;
              issue_kind = EV_SUB;
            end else begin
              next_state = ST_WDATA_ACK;
              issue = 1'b1;
              issue_kind = EV_WR;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            next_loaded = 1'b0;
            next_cnt = `ICPC_CNT_RST;
            next_state = (rw == `ICPC_DIR_READ) ? ST_RDATA : ST_SUB;
          end
        end
        ST_SUB_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            next_state = ST_WDATA;
            next_cnt = `ICPC_CNT_RST;
          end
        end
        ST_RDATA: begin
          if (!busy && !loaded) begin
            next_txsh = rd_data;
            next_loaded = 1'b1;
          end else if (scl_fall && loaded) begin
            next_txsh = {txsh[6:0], 1'b0};
            next_cnt = 4'(cnt + `ICPC_CNT_ONE);
            if (cnt == `ICPC_TX_LAST) begin
              next_state = ST_RDATA_ACK;
              next_cnt = `ICPC_CNT_RST;
            end
          end
        end
        ST_RDATA_ACK: begin
          if (scl_rise) begin
            next_mack = ~sda_s;
          end else if (scl_fall) begin
            if (mack) begin
              next_state = ST_RDATA;
              next_loaded = 1'b0;
              issue = 1'b1;
              issue_kind = EV_RD;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Bit engine registers
  always_ff @(posedge clk_link_i) begin
    if (!link_rst_n) begin
      state <= ST_IDLE;
      cnt <= `ICPC_CNT_RST;
      shreg <= `ICPC_BYTE_RST;
      txsh <= `ICPC_BYTE_RST;
      loaded <= 1'b0;
      rw <= 1'b0;
      mack <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shreg <= next_shreg;
      txsh <= next_txsh;
      loaded <= next_loaded;
      rw <= next_rw;
      mack <= next_mack;
    end
  end

  // Request word held stable until the toggle comes back
  always_ff @(posedge clk_link_i) begin
    if (!link_rst_n) begin
      req_tog <= 1'b0;
      req_kind <= EV_WR;
      req_byte <= `ICPC_BYTE_RST;
    end else if (issue) begin
      req_tog <= ~req_tog;
      req_kind <= issue_kind;
      req_byte <= issue_byte;
    end
  end

  // Pin drivers; clock is held low while the register side answers
  always_ff @(posedge clk_link_i) begin
    if (!link_rst_n) begin
      sda_low <= 1'b0;
      scl_hold <= 1'b0;
    end else begin
      sda_low <= ack_state | ((state == ST_RDATA) & loaded & ~txsh[7]);
      scl_hold <= wait_data & (scl_hold | ~scl_s);
    end
  end

  // Open-drain outputs only ever pull low
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign sda_oe_n_o = ~sda_low;
  assign scl_oe_n_o = ~scl_hold;

  // ---------------- Register domain logic ----------------

  // CRC step over one byte, MSB first
  function automatic logic [7:0] icpc_crc8(input logic [7:0] c_in, input logic [7:0] d_in);
    logic [7:0] c;
    c = c_in ^ d_in;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ `ICPC_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // Event and location decode
  wire req_edge = req_s ^ req_d;
  wire is_sub = req_edge & (req_kind == EV_SUB);
  wire is_wr = req_edge & (req_kind == EV_WR);
  wire is_rd = req_edge & (req_kind == EV_RD);
  wire on_page0 = page == `ICPC_PAGE_ZERO;
  wire in_xbook = book == `ICPC_BOOK_XOR;
  wire hit_page = ptr == `ICPC_REG_PAGE;
  wire hit_book = on_page0 & (ptr == `ICPC_REG_BOOK);
  wire hit_crc = on_page0 & (ptr == `ICPC_REG_CRC);
  wire hit_xor = on_page0 & in_xbook & (ptr == `ICPC_REG_XOR);
  wire switching = hit_page | hit_book;
  wire crc_clear = is_wr & hit_crc & (req_byte == `ICPC_CSUM_CLEAR);
  wire xor_clear = is_wr & hit_xor & (req_byte == `ICPC_CSUM_CLEAR);
  wire xor_qual = in_xbook & ~on_page0 & ~hit_page;
  wire mem_we = is_wr & ~switching & ~hit_crc & ~hit_xor;

  // Checksum next values; a clear wins and folds nothing
  wire [7:0] next_crc = crc_clear ? `ICPC_CSUM_RST :
                        (is_wr & ~switching) ? icpc_crc8(crc, req_byte) : crc;
  wire [7:0] next_xsum = xor_clear ? `ICPC_CSUM_RST :
                         (is_wr & xor_qual) ? (xsum ^ req_byte) : xsum;

  // Read selection; paging registers shadow the plain array
  wire [7:0] rd_sel = hit_page ? page :
                      hit_book ? book :
                      hit_crc ? crc :
                      hit_xor ? xsum :
                      mem[ptr];

  // Edge history of the request toggle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      req_d <= 1'b0;
      ack_tog <= 1'b0;
    end else begin
      req_d <= req_s;
      ack_tog <= ack_tog ^ req_edge;
    end
  end

  // Subaddress pointer advances after every data byte either way
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ptr <= `ICPC_PTR_RST;
    end else if (is_sub) begin
      ptr <= req_byte;
    end else if (is_wr || is_rd) begin
      ptr <= 8'(ptr + 8'h01);
    end
  end

  // Page and book selection, full 8-bit range
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      page <= `ICPC_PAGE_RST;
      book <= `ICPC_BOOK_RST;
    end else begin
      if (is_wr && hit_page) begin
        page <= req_byte;
      end
      if (is_wr && hit_book) begin
        book <= req_byte;
      end
    end
  end

  // Both checksums run side by side; reads never touch them
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      crc <= `ICPC_CSUM_RST;
      xsum <= `ICPC_CSUM_RST;
    end else begin
      crc <= next_crc;
      xsum <= next_xsum;
    end
  end

  // Read data captured for the link side
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rd_data <= `ICPC_BYTE_RST;
    end else if (is_rd) begin
      rd_data <= rd_sel;
    end
  end

  // Plain storage, one page deep; not cleared by reset to stay a RAM
  always_ff @(posedge clk_sys_i) begin
    if (mem_we) begin
      mem[ptr] <= req_byte;
    end
  end

  assign page_o = page;
  assign book_o = book;

endmodule

`default_nettype wire

// File: icpc_control_port_monitor.sv
// Concurrent checks on the control port pins
`timescale 1ns/100ps
`default_nettype none

module icpc_monitor (
  input wire logic clk_sys_i,       // Register clock
  input wire logic rst_n_i,         // Reset, active low
  input wire logic clk_link_i,      // Link clock
  input wire logic power_down_n_i,  // Power-down pin
  input wire logic [1:0] strap_i,   // Strap level
  input wire logic scl_i,           // Clock wire
  input wire logic scl_o,           // Clock drive value
  input wire logic scl_oe_n_o,      // Clock drive enable
  input wire logic sda_i,           // Data wire
  input wire logic sda_o,           // Data drive value
  input wire logic sda_oe_n_o,      // Data drive enable
  input wire logic [7:0] page_o,    // Page
  input wire logic [7:0] book_o     // Book
);
  // Open-drain pins may only ever pull low
  a_scl_value_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) scl_o == 1'b0)
    else $error("scl drive value not zero");
  a_sda_value_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) sda_o == 1'b0)
    else $error("sda drive value not zero");
  // Power-down lets go of the wires and freezes paging
  a_pdn_releases: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
    !power_down_n_i [*8] |-> scl_oe_n_o && sda_oe_n_o) else $error("pins driven in power down");
  a_pdn_holds_regs: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !power_down_n_i [*4] |-> $stable(page_o) && $stable(book_o)) else $error("paging moved in power down");
  // Stretching is short and starts only in a low phase
  a_stretch_bounded: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
    !scl_oe_n_o |-> ##[1:60] scl_oe_n_o) else $error("clock stretch too long");
  a_stretch_low: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
    $fell(scl_oe_n_o) |-> !$past(scl_i)) else $error("stretch began with clock high");
  // Data changes while clock high would fake start or stop
  a_sda_scl_low: assert property (@(posedge clk_link_i) disable iff (!rst_n_i)
    $changed(sda_oe_n_o) |-> !scl_i) else $error("data drive changed with clock high");
  a_book_page_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $changed(book_o) |-> page_o == 8'h00) else $error("book changed off page zero");
endmodule

bind icpc_control_port icpc_monitor icpc_monitor_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .clk_link_i(clk_link_i), .power_down_n_i(power_down_n_i), .strap_i(strap_i), .scl_i(scl_i),
  .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
  .page_o(page_o), .book_o(book_o));

`default_nettype wire

// File: icpc_control_port_tb_top.sv
// Self-checking bench for the paging checksum control port
`include "icpc_map.svh"
`timescale 1ns/100ps
`default_nettype none

module icpc_control_port_tb_top;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst_n = 1'b0;
  logic power_down_n = 1'b1;
  logic [1:0] strap = 2'h0;
  logic scl_oe_n, sda_oe_n, scl_drv, sda_drv, m_scl, m_sda, host_to;
  logic [7:0] page, book, m_page, m_book, m_ptr, crc_x, xor_x;
  // Open-drain wires with pull-ups; a released pin reads high
  wire scl = (scl_oe_n ? 1'b1 : scl_drv) & ~m_scl;
  wire sda = (sda_oe_n ? 1'b1 : sda_drv) & ~m_sda;
  int n_mismatch = 0;
  int samples_checked = 0;
  int seed = 61;

  icpc_control_port icpc_control_port_i (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .clk_link_i(clk_link),
    .power_down_n_i(power_down_n), .strap_i(strap), .scl_i(scl), .scl_o(scl_drv), .scl_oe_n_o(scl_oe_n),
    .sda_i(sda), .sda_o(sda_drv), .sda_oe_n_o(sda_oe_n), .page_o(page), .book_o(book));
  icpc_host_model host (.scl_i(scl), .sda_i(sda), .scl_pull_o(m_scl), .sda_pull_o(m_sda), .timeout_o(host_to));

  // Link clock offset so the domains never line up
  initial forever #5 clk_sys = ~clk_sys;
  initial begin
    #3.7;
    forever #6 clk_link = ~clk_link;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge host_to) begin
    n_mismatch++;
    final_report();
  end

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    c = c ^ d;
    for (int i = 0; i < 8; i++) c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    return c;
  endfunction
  // Expected paging and checksum effect of one written byte
  task automatic model(input logic [7:0] d);
    if (m_ptr == 8'h00) m_page = d;
    else if (m_page == 8'h00 && m_ptr == 8'h7F) m_book = d;
    else begin
      crc_x = (m_page == 8'h00 && m_ptr == 8'h7E && d == 8'h00) ? 8'h00 : crc8(crc_x, d);
      if (m_book == 8'h8C && m_page == 8'h00 && m_ptr == 8'h7D && d == 8'h00) xor_x = 8'h00;
      else if (m_book == 8'h8C && m_page != 8'h00) xor_x = xor_x ^ d;
    end
    m_ptr = m_ptr + 8'h01;
  endtask

  task automatic do_reset(input logic [1:0] s);
    @(posedge clk_sys);
    #1 rst_n = 1'b0;
    strap = s;
    repeat (10) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (10) @(posedge clk_sys);
    m_page = 8'h00;
    m_book = 8'h00;
    crc_x = 8'h00;
    xor_x = 8'h00;
  endtask
  task automatic probe(input logic [6:0] ad, input logic exp);
    logic a;
    host.start();
    host.put_byte({ad, 1'b0}, a);
    host.stop();
    check({7'h00, a}, {7'h00, exp});
  endtask
  task automatic wr(input logic [7:0] sub, input logic [7:0] d [$]);
    logic a;
    m_ptr = sub;
    host.start();
    host.put_byte({`ICPC_ADDR_HI, strap, 1'b0}, a);
    check({7'h00, a}, 8'h01);
    host.put_byte(sub, a);
    check({7'h00, a}, 8'h01);
    foreach (d[i]) begin
      host.put_byte(d[i], a);
      check({7'h00, a}, 8'h01);
      model(d[i]);
    end
    host.stop();
    check(page, m_page);
    check(book, m_book);
  endtask
  task automatic rd(input logic [7:0] sub, input logic [7:0] exp [$]);
    logic a;
    logic [7:0] b;
    host.start();
    host.put_byte({`ICPC_ADDR_HI, strap, 1'b0}, a);
    check({7'h00, a}, 8'h01);
    host.put_byte(sub, a);
    check({7'h00, a}, 8'h01);
    host.start();
    host.put_byte({`ICPC_ADDR_HI, strap, 1'b1}, a);
    check({7'h00, a}, 8'h01);
    foreach (exp[i]) begin
      host.get_byte(i == exp.size() - 1, b);
      check(b, exp[i]);
    end
    host.stop();
  endtask

  initial begin
    logic [7:0] a;
    logic [7:0] q [$];
    logic [7:0] c [$];
    // Every strap code, last one at standard-mode speed
    for (int s = 0; s < 4; s++) begin
      do_reset(2'(s));
      if (s == 3) host.t_lo = 4700;
      if (s == 3) host.t_hi = 4000;
      probe({`ICPC_ADDR_HI, 2'(s)}, 1'b1);
      // Back to fast mode early; slow phases cost most of the run time
      host.t_lo = 1000;
      host.t_hi = 600;
      probe({`ICPC_ADDR_HI, ~2'(s)}, 1'b0);
      $display("Strap test %0d done", s);
    end
    // Book 0 access needs no audio clock first
    wr(`ICPC_REG_PAGE, {8'hFF});
    wr(`ICPC_REG_PAGE, {8'h00});
    wr(`ICPC_REG_BOOK, {`ICPC_BOOK_XOR});
    $display("Paging test done");
    wr(`ICPC_REG_XOR, {8'h00});
    wr(`ICPC_REG_CRC, {8'h00});
    wr(`ICPC_REG_PAGE, {8'h01});
    a = 8'h10 + 8'($random(seed) & 32'h3F);
    repeat (3) q.push_back(8'($random(seed)));
    wr(a, q);
    rd(a, q);
    wr(`ICPC_REG_PAGE, {8'h00});
    // Five coefficients in one ascending burst right after the book byte
    c.push_back(`ICPC_BOOK_BIQUAD);
    repeat (5) c.push_back(8'($random(seed)));
    // No settle wait modelled: the port has no timer, the host owns that delay
    wr(`ICPC_REG_BOOK, c);
    wr(`ICPC_REG_BOOK, {`ICPC_BOOK_XOR});
    wr(a, {8'($random(seed))});
    rd(`ICPC_REG_XOR, {xor_x, crc_x});
    $display("Checksum test done");
    // Power-down: bus ignored, then answered again
    @(posedge clk_sys);
    #1 power_down_n = 1'b0;
    repeat (10) @(posedge clk_sys);
    probe({`ICPC_ADDR_HI, strap}, 1'b0);
    @(posedge clk_sys);
    #1 power_down_n = 1'b1;
    repeat (10) @(posedge clk_sys);
    probe({`ICPC_ADDR_HI, strap}, 1'b1);
    $display("Power-down test done");
    final_report();
  end
endmodule

`default_nettype wire

// File: icpc_host_model.sv
// Behavioural bus controller for the two-wire pins
`timescale 1ns/100ps
`default_nettype none

module icpc_host_model (
  input wire logic scl_i,   // Clock wire level
  input wire logic sda_i,   // Data wire level
  output logic scl_pull_o,  // High pulls clock low
  output logic sda_pull_o,  // High pulls data low
  output logic timeout_o    // Stretch wait ran out
);
  // Phase lengths in ns, fast mode by default
  int t_lo = 1000;
  int t_hi = 600;
  initial begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
    timeout_o = 1'b0;
  end
  // Release clock, honour stretching under a bound
  task automatic clk_high();
    int n;
    n = 0;
    scl_pull_o = 1'b0;
    while (scl_i !== 1'b1 && n < 300) begin
      #10;
      n++;
    end
    if (n >= 300) timeout_o = 1'b1;
  endtask
  // Data set a quarter into the low phase, sampled once clock is high
  task automatic bit_io(input logic b, output logic r);
    #(t_lo / 4);
    sda_pull_o = !b;
    #(t_lo - t_lo / 4);
    clk_high();
    r = sda_i;
    #(t_hi);
    scl_pull_o = 1'b1;
  endtask
  task automatic start();
    sda_pull_o = 1'b0;
    #(t_lo);
    clk_high();
    #(t_hi);
    sda_pull_o = 1'b1;
    #(t_hi);
    scl_pull_o = 1'b1;
  endtask
  task automatic stop();
    #(t_lo / 4);
    sda_pull_o = 1'b1;
    #(t_lo);
    clk_high();
    #(t_hi);
    sda_pull_o = 1'b0;
    #(t_hi);
  endtask
  // Ninth bit released so the device can answer
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

`default_nettype wire

// File: icpc_map.svh
// Register offsets, field values and bus constants of the control port
`ifndef ICPC_MAP_SVH
`define ICPC_MAP_SVH

// Fixed upper bits of the 7-bit bus target address
`define ICPC_ADDR_HI 5'h13
// Special locations
`define ICPC_REG_PAGE 8'h00
`define ICPC_REG_XOR 8'h7D
`define ICPC_REG_CRC 8'h7E
`define ICPC_REG_BOOK 8'h7F
// Page and book values; page zero and the XOR book steer decoding
`define ICPC_PAGE_ZERO 8'h00
`define ICPC_BOOK_XOR 8'h8C
`define ICPC_BOOK_BIQUAD 8'hAA
// Checksum constants
`define ICPC_CSUM_CLEAR 8'h00
`define ICPC_CRC_POLY 8'h07
// Reset values
`define ICPC_PAGE_RST 8'h00
`define ICPC_BOOK_RST 8'h00
`define ICPC_CSUM_RST 8'h00
`define ICPC_PTR_RST 8'h00
`define ICPC_BYTE_RST 8'h00
`define ICPC_STRAP_RST 2'h0
// Bit counting on the bus
`define ICPC_CNT_RST 4'h0
`define ICPC_CNT_ONE 4'h1
`define ICPC_RX_LAST 4'h8
`define ICPC_TX_LAST 4'h7
// Direction bit values
`define ICPC_DIR_READ 1'b1

`endif

// File: icpc_pkg.sv
// Types shared by the control port modules
`default_nettype none

package icpc_pkg;

  // Link-side bit engine states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_SUB,
    ST_SUB_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } icpc_state_t;

  // Events handed from the link domain to the register domain
  typedef enum logic [1:0] {
    EV_SUB,
    EV_WR,
    EV_RD
  } icpc_event_t;

endpackage

`default_nettype wire

// File: icpc_sync2.sv
// Two flip-flop level synchroniser, one stage pair per bit
`timescale 1ns/100ps
`default_nettype none

module icpc_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,        // Destination clock
  input wire logic [W-1:0] d_i,  // Asynchronous level
  output logic [W-1:0] q_o       // Synchronised level
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    meta <= d_i;
    q_o <= meta;
  end

endmodule

`default_nettype wire
